// *** ppce_pkg.sv ***
// Contract
// (RULE_01) PLL request rejects input frequency outside 10000..25000 kHz as bad frequency.
// (RULE_02) PLL request rejects target clock outside 1..30000 kHz as bad frequency.
// (RULE_03) On a frequency failure the input frequency is echoed as second result.
// (RULE_04) Every chosen clock setup keeps the main clock at or below 30 MHz.
// (RULE_05) If plain division of the input reaches the target, the PLL is bypassed.
// (RULE_06) Found dividers are applied and main clock switched to PLL output if needed.
// (RULE_07) Policy codes: 0 exact, 1 at most, 2 at least, 3 nearest.
// (RULE_08) Exact policy succeeds only when the target is produced precisely.
// (RULE_09) At-most policy never yields a clock above the target.
// (RULE_10) At-least policy never yields a clock below the target.
// (RULE_11) Nearest policy yields the achievable clock closest to the target.
// (RULE_12) Undefined policy returns code 2, no change, input frequency echoed.
// (RULE_13) No satisfying setup returns code 3, no change, input frequency echoed.
// (RULE_14) Lock time-out of zero polls for lock without limit.
// (RULE_15) Nonzero time-out bounds lock polls; expiry gives code 4, setup restored.
// (RULE_16) Success returns code 0 and the achieved clock in kHz.
// (RULE_17) Caller should set poll limit to PLL output in Hz divided by 10000.
// (RULE_18) Caller selects PLL reference, routes main clock from PLL input, divider 1.
// (RULE_19) Power profiles: 0 baseline, 1 fast, 2 balanced, 3 frugal; code 0 on success.
// (RULE_20) Undefined power profile returns code 2 and leaves power setup unchanged.
// (RULE_21) Power request main clock must be 1..30 MHz, else code 1, no change.
// (RULE_22) Caller gives core clock 1..30 MHz and core divider 1 before power request.
//
// Purpose: constants and types of the power profile clock engine
// Assumes: 20 MHz system clock, plain register port
// Notes: frequencies in kHz for clock requests, MHz for power requests

package ppce_pkg;

    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_PARAM0 = 8'h00;
    localparam logic [7:0] OFS_PARAM1 = 8'h04;
    localparam logic [7:0] OFS_PARAM2 = 8'h08;
    localparam logic [7:0] OFS_PARAM3 = 8'h0C;
    localparam logic [7:0] OFS_COMMAND = 8'h10;
    localparam logic [7:0] OFS_RESULT0 = 8'h14;
    localparam logic [7:0] OFS_RESULT1 = 8'h18;
    localparam logic [7:0] OFS_CLOCK_SETUP = 8'h1C;
    localparam logic [7:0] OFS_PROFILE = 8'h20;

    // command codes written to the command register
    localparam logic [31:0] CMD_SET_PLL = 32'h0000_0001;
    localparam logic [31:0] CMD_SET_POWER = 32'h0000_0002;

    // frequency limits
    localparam logic [31:0] FIN_MIN_KHZ = 32'd10000;
    localparam logic [31:0] FIN_MAX_KHZ = 32'd25000;
    localparam logic [31:0] TGT_MIN_KHZ = 32'd1;
    localparam logic [31:0] TGT_MAX_KHZ = 32'd30000;
    localparam logic [23:0] MAIN_MAX_KHZ = 24'd30000;
    localparam logic [31:0] PWR_MIN_MHZ = 32'd1;
    localparam logic [31:0] PWR_MAX_MHZ = 32'd30;
    localparam logic [23:0] CCO_MIN_KHZ = 24'd156000;
    localparam logic [23:0] CCO_MAX_KHZ = 24'd320000;

    // divider search ranges
    localparam logic [5:0] MULT_MAX = 6'd32;
    localparam logic [7:0] DIV_MAX = 8'd255;

    // matching policies
    localparam logic [31:0] MATCH_EXACT_POLICY = 32'd0;
    localparam logic [31:0] MATCH_AT_MOST_POLICY = 32'd1;
    localparam logic [31:0] MATCH_AT_LEAST_POLICY = 32'd2;
    localparam logic [31:0] MATCH_NEAREST_POLICY = 32'd3;

    // clock request result codes
    localparam logic [31:0] PLL_RESULT_OK = 32'd0;
    localparam logic [31:0] PLL_RESULT_BAD_FREQUENCY = 32'd1;
    localparam logic [31:0] PLL_RESULT_BAD_POLICY = 32'd2;
    localparam logic [31:0] PLL_RESULT_NO_SOLUTION = 32'd3;
    localparam logic [31:0] PLL_RESULT_LOCK_TIMEOUT = 32'd4;

    // power profiles and result codes
    localparam logic [31:0] PROFILE_BASELINE = 32'd0;
    localparam logic [31:0] PROFILE_FAST = 32'd1;
    localparam logic [31:0] PROFILE_BALANCED = 32'd2;
    localparam logic [31:0] PROFILE_FRUGAL = 32'd3;
    localparam logic [31:0] POWER_RESULT_OK = 32'd0;
    localparam logic [31:0] POWER_RESULT_BAD_FREQUENCY = 32'd1;
    localparam logic [31:0] POWER_RESULT_BAD_PROFILE = 32'd2;

    // values after reset
    localparam logic [6:0] PLL_CTL_RST = 7'h00;
    localparam logic [7:0] CORE_DIV_RST = 8'h01;
    localparam logic [1:0] PROFILE_RST = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEARCH = 3'b010,
        ST_LOCK = 3'b100
    } ppce_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } ppce_bus_t;

    // pll_divider_control = {post code[1:0], feedback mult minus 1 [4:0]}
    typedef struct packed {
        logic [6:0] pll_divider_control;
        logic [7:0] core_clock_divider;
        logic main_from_pll;
    } ppce_clk_t;

endpackage

// *** ppce_engine.sv ***
// Purpose: clock path and power profile command engine
// Assumes: software keeps parameters stable while busy; lock pin is asynchronous
// Notes: one request at a time; commands written while busy are dropped
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps

module ppce_engine
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // register port
    input wire ppce_pkg::ppce_bus_t i_bus,
    output logic [31:0] o_rdata,
    // pll lock pin
    input wire logic i_pll_locked,
    // clock path and power settings
    output ppce_pkg::ppce_clk_t o_clk,
    output logic [1:0] o_profile,
    output logic o_busy
);
    import ppce_pkg::*;

    typedef struct packed {
        ppce_state_t st;
        logic [3:0][31:0] prm;
        logic [31:0] res0;
        logic [31:0] res1;
        logic [31:0] rdata;
        logic [1:0] lock_s;
        logic [5:0] m;
        logic [7:0] d;
        logic [5:0] best_m;
        logic [7:0] best_d;
        logic [23:0] best_f;
        logic found;
        logic stop;
        logic [31:0] polls;
        ppce_clk_t clk;
        ppce_clk_t saved;
        logic [1:0] profile;
    } ppce_regs_t;

    ppce_regs_t q;
    ppce_regs_t n;

    function automatic logic [23:0] absdiff(input logic [23:0] a, input logic [23:0] b);
        absdiff = (a > b) ? (a - b) : (b - a);
    endfunction

    // post divider code whose oscillator frequency lands in range
    function automatic logic [1:0] post_code(input logic [23:0] fout);
        logic [1:0] code;
        code = 2'h3;
        for (int i = 3; i >= 0; i--)
        begin
            if (((fout << (i + 1)) >= CCO_MIN_KHZ) && ((fout << (i + 1)) <= CCO_MAX_KHZ))
            begin
                code = 2'(i);
            end
        end
        post_code = code;
    endfunction

    logic [23:0] fin;
    logic [23:0] tgt;
    logic [23:0] main_khz;
    logic [31:0] tgt_x_d;
    logic [23:0] f;
    logic hit;
    logic better;
    logic exact;
    logic [31:0] pol;

    always_comb
    begin
        n = q;
        fin = q.prm[0][23:0];
        tgt = q.prm[1][23:0];
        pol = q.prm[2];
        main_khz = 24'(fin * q.m);
        tgt_x_d = 32'(tgt * q.d);
        f = main_khz / 24'(q.d);
        exact = ({8'h00, main_khz} == tgt_x_d);
        hit = 1'b0;
        better = 1'b0;

        n.lock_s = {q.lock_s[0], i_pll_locked};
        n.rdata = 32'h0;

        if (i_bus.re)
        begin
            unique case (i_bus.addr)
                OFS_PARAM0: n.rdata = q.prm[0];
                OFS_PARAM1: n.rdata = q.prm[1];
                OFS_PARAM2: n.rdata = q.prm[2];
                OFS_PARAM3: n.rdata = q.prm[3];
                OFS_COMMAND: n.rdata = {31'h0, (q.st != ST_IDLE)};
                OFS_RESULT0: n.rdata = q.res0;
                OFS_RESULT1: n.rdata = q.res1;
                OFS_CLOCK_SETUP: n.rdata = {16'h0, q.clk};
                OFS_PROFILE: n.rdata = {30'h0, q.profile};
                default: n.rdata = 32'h0;
            endcase
        end

        unique case (q.st)
            ST_IDLE:
            begin
                if (i_bus.we)
                begin
                    unique case (i_bus.addr)
                        OFS_PARAM0: n.prm[0] = i_bus.wdata;
                        OFS_PARAM1: n.prm[1] = i_bus.wdata;
                        OFS_PARAM2: n.prm[2] = i_bus.wdata;
                        OFS_PARAM3: n.prm[3] = i_bus.wdata;
                        default: n.prm = q.prm;
                    endcase
                end
                if (i_bus.we && (i_bus.addr == OFS_COMMAND) && (i_bus.wdata == CMD_SET_PLL))
                begin
                    n.res1 = q.prm[0];
                    if ((q.prm[0] < FIN_MIN_KHZ) || (q.prm[0] > FIN_MAX_KHZ)) // RULE_01
                    begin
                        n.res0 = PLL_RESULT_BAD_FREQUENCY; // RULE_03
                    end
                    else if ((q.prm[1] < TGT_MIN_KHZ) || (q.prm[1] > TGT_MAX_KHZ) // RULE_02
                        || (32'(tgt * DIV_MAX) < {8'h00, fin}))
                    begin
                        // below what the largest core divider can reach
                        n.res0 = PLL_RESULT_BAD_FREQUENCY; // RULE_03
                    end
                    else if (pol > MATCH_NEAREST_POLICY) // RULE_07
                    begin
                        n.res0 = PLL_RESULT_BAD_POLICY; // RULE_12
                    end
                    else
                    begin
                        n.st = ST_SEARCH;
                        n.m = 6'd1;
                        n.d = 8'd1;
                        n.found = 1'b0;
                        n.stop = 1'b0;
                        n.saved = q.clk;
                    end
                end
                else if (i_bus.we && (i_bus.addr == OFS_COMMAND)
                    && (i_bus.wdata == CMD_SET_POWER))
                begin
                    if ((q.prm[0] < PWR_MIN_MHZ) || (q.prm[0] > PWR_MAX_MHZ)) // RULE_21
                    begin
                        n.res0 = POWER_RESULT_BAD_FREQUENCY;
                    end
                    else if (q.prm[1] > PROFILE_FRUGAL) // RULE_20
                    begin
                        n.res0 = POWER_RESULT_BAD_PROFILE;
                    end
                    else
                    begin
                        n.profile = q.prm[1][1:0]; // RULE_19
                        n.res0 = POWER_RESULT_OK;
                    end
                end
            end

            ST_SEARCH:
            begin
                if (q.stop || (q.m > MULT_MAX))
                begin
                    if (!q.found)
                    begin
                        n.res0 = PLL_RESULT_NO_SOLUTION; // RULE_13
                        n.res1 = q.prm[0];
                        n.st = ST_IDLE;
                    end
                    else if (q.best_m == 6'd1)
                    begin
                        // plain division reaches the target: no pll, no lock wait
                        n.clk.core_clock_divider = q.best_d; // RULE_05
                        n.clk.main_from_pll = 1'b0;
                        n.res0 = PLL_RESULT_OK; // RULE_16
                        n.res1 = {8'h00, q.best_f};
                        n.st = ST_IDLE;
                    end
                    else
                    begin
                        n.clk.pll_divider_control = {post_code(24'(fin * q.best_m)),
                            5'(q.best_m - 6'd1)}; // RULE_06
                        n.clk.core_clock_divider = q.best_d;
                        n.clk.main_from_pll = 1'b1;
                        n.polls = 32'h0;
                        n.st = ST_LOCK;
                    end
                end
                else if (main_khz > MAIN_MAX_KHZ) // RULE_04
                begin
                    // larger multipliers only raise the main clock further
                    n.stop = 1'b1;
                end
                else
                begin
                    unique case (pol[1:0])
                        2'd0: hit = exact; // RULE_08
                        2'd1: hit = ({8'h00, main_khz} <= tgt_x_d); // RULE_09
                        2'd2: hit = ({8'h00, main_khz} >= tgt_x_d); // RULE_10
                        2'd3: hit = 1'b1; // RULE_11
                    endcase
                    unique case (pol[1:0])
                        2'd0: better = 1'b1;
                        2'd1: better = (f > q.best_f);
                        2'd2: better = (f < q.best_f);
                        2'd3: better = (absdiff(f, tgt) < absdiff(q.best_f, tgt)); // RULE_11
                    endcase
                    // first hit wins ties, so the bypass setup (mult 1) is preferred
                    if (hit && (!q.found || better || exact)) // RULE_05
                    begin
                        n.found = 1'b1;
                        n.best_m = q.m;
                        n.best_d = q.d;
                        n.best_f = exact ? tgt : f;
                    end
                    if (hit && exact)
                    begin
                        n.stop = 1'b1;
                    end
                    if (q.d == DIV_MAX)
                    begin
                        n.d = 8'd1;
                        n.m = q.m + 6'd1;
                    end
                    else
                    begin
                        n.d = q.d + 8'd1;
                    end
                end
            end

            ST_LOCK:
            begin
                n.polls = q.polls + 32'h1;
                if (q.lock_s[1])
                begin
                    n.res0 = PLL_RESULT_OK; // RULE_16
                    n.res1 = {8'h00, q.best_f};
                    n.st = ST_IDLE;
                end
                else if ((q.prm[3] != 32'h0) && ((q.polls + 32'h1) == q.prm[3])) // RULE_14
                begin
                    n.clk = q.saved; // RULE_15
                    n.res0 = PLL_RESULT_LOCK_TIMEOUT;
                    n.res1 = q.prm[0];
                    n.st = ST_IDLE;
                end
            end

            default:
            begin
                n.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.d <= 8'd1;
            q.m <= 6'd1;
            q.clk <= '{pll_divider_control: PLL_CTL_RST, core_clock_divider: CORE_DIV_RST,
                main_from_pll: 1'b0};
            q.saved <= '{pll_divider_control: PLL_CTL_RST, core_clock_divider: CORE_DIV_RST,
                main_from_pll: 1'b0};
            q.profile <= PROFILE_RST;
        end
        else
        begin
            q <= n;
        end
    end

    assign o_rdata = q.rdata;
    assign o_clk = q.clk;
    assign o_profile = q.profile;
    assign o_busy = (q.st != ST_IDLE);

endmodule

// *** ppce_engine_properties.sv ***
// Purpose: port checker for the clock and power command engine
// Assumes: bound to every ppce_engine instance
// Notes: only sees the top module ports
`timescale 1ns/1ps

module ppce_engine_chk
    import ppce_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // watched ports
    input wire ppce_pkg::ppce_bus_t i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic i_pll_locked,
    input wire ppce_pkg::ppce_clk_t o_clk,
    input wire logic [1:0] o_profile,
    input wire logic o_busy
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    logic cmd_pll;
    logic cmd_pwr;
    assign cmd_pll = i_bus.we && i_bus.addr == OFS_COMMAND && i_bus.wdata == CMD_SET_PLL;
    assign cmd_pwr = i_bus.we && i_bus.addr == OFS_COMMAND && i_bus.wdata == CMD_SET_POWER;

    a_rdata_idle: assert property (!$past(i_bus.re) |-> o_rdata == 32'h0)
        else $error("read data outside a read answer");
    a_busy_cause: assert property ($rose(o_busy) |-> $past(cmd_pll))
        else $error("busy rose without a clock request");
    a_power_idle: assert property (cmd_pwr && !o_busy |=> !o_busy)
        else $error("power request made the engine busy");
    a_profile_cause: assert property ($changed(o_profile) |-> $past(cmd_pwr && !o_busy))
        else $error("profile changed without a power request");
    a_busy_profile: assert property (o_busy |=> $stable(o_profile))
        else $error("profile changed during a clock request");
    a_clk_hold: assert property ($changed(o_clk) |-> $past(o_busy))
        else $error("clock setup changed outside a clock request");
    a_div_nonzero: assert property (o_clk.core_clock_divider != 8'h00)
        else $error("core clock divider is zero");
    a_lock_done: assert property ($rose(o_clk.main_from_pll) ##0 i_pll_locked [*6] |=> !o_busy)
        else $error("engine still busy with lock present");
endmodule

bind ppce_engine ppce_engine_chk chk_u (.i_clk_sys, .i_rst, .i_bus, .o_rdata,
    .i_pll_locked, .o_clk, .o_profile, .o_busy);

// *** ppce_engine_tb.sv ***
// Purpose: self-checking bench for the clock and power command engine
// Assumes: register port with read data one cycle after the strobe
// Notes: frequencies in kHz for clock requests, MHz for power requests
`timescale 1ns/1ps

module ppce_engine_tb;
    import ppce_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    ppce_bus_t bus_s = '0;
    logic pll_lock = 1'b1;
    logic [31:0] rdata;
    ppce_clk_t clk_cfg;
    logic [1:0] profile;
    logic busy;
    logic [31:0] v;
    logic [31:0] s0;
    int err_total = 0;
    int n_compared = 0;
    // 12000 and 24000 kHz
    localparam logic [31:0] F12 = 32'h0000_2EE0;
    localparam logic [31:0] F24 = 32'h0000_5DC0;

    always #25 clk_sys = ~clk_sys;

    ppce_engine dut_u (
        .i_clk_sys(clk_sys),
        .i_rst(rst),
        .i_bus(bus_s),
        .o_rdata(rdata),
        .i_pll_locked(pll_lock),
        .o_clk(clk_cfg),
        .o_profile(profile),
        .o_busy(busy)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_s <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk_sys);
        bus_s.we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus_s <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge clk_sys);
        bus_s.re <= 1'b0;
        // the answer stands until this edge; take it before it is replaced
        @(posedge clk_sys);
        d = rdata;
    endtask

    task automatic wait_idle();
        int n = 0;
        @(posedge clk_sys);
        #1;
        while (busy !== 1'b0 && n < 20000)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 20000)
        begin
            err_total++;
            conclude();
        end
    endtask

    task automatic start(input logic [31:0] fin, tgt, pol, lim);
        wr(OFS_PARAM0, fin);
        wr(OFS_PARAM1, tgt);
        wr(OFS_PARAM2, pol);
        wr(OFS_PARAM3, lim);
        wr(OFS_COMMAND, CMD_SET_PLL);
    endtask

    task automatic results(input logic [31:0] r0, r1);
        logic [31:0] d;
        rd(OFS_RESULT0, d);
        check("result0", d, r0);
        rd(OFS_RESULT1, d);
        check("result1", d, r1);
    endtask

    task automatic pll(input logic [31:0] fin, tgt, pol, lim, r0, r1);
        start(fin, tgt, pol, lim);
        wait_idle();
        results(r0, r1);
    endtask

    task automatic pwr(input logic [31:0] mhz, prof, r0);
        logic [31:0] d;
        wr(OFS_PARAM0, mhz);
        wr(OFS_PARAM1, prof);
        wr(OFS_PARAM2, mhz);
        wr(OFS_COMMAND, CMD_SET_POWER);
        rd(OFS_RESULT0, d);
        check("power result", d, r0);
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(OFS_CLOCK_SETUP, v);
        check("setup after reset", v, 32'h0000_0002);
        rd(8'h24, v);
        check("unmapped", v, 32'h0000_0000);
        $display("test reset done");
        pll(F12, 32'h0000_EA60, 32'h0, 32'h0, 32'h1, F12);
        pll(32'h0000_270F, 32'h0000_1770, 32'h0, 32'h0, 32'h1, 32'h0000_270F);
        pll(32'h0000_61A9, 32'h0000_1770, 32'h0, 32'h0, 32'h1, 32'h0000_61A9);
        pll(F12, 32'h0000_0028, 32'h1, 32'h0, 32'h1, F12);
        pll(F12, 32'h0000_0000, 32'h3, 32'h0, 32'h1, F12);
        pll(F12, F24, 32'h4, 32'h0, 32'h2, F12);
        pll(F12, 32'h0000_61A8, 32'h0, 32'h0, 32'h3, F12);
        rd(OFS_CLOCK_SETUP, v);
        check("setup after refusals", v, 32'h0000_0002);
        $display("test refusals done");
        pll(F12, 32'h0000_1770, 32'h0, 32'h0, 32'h0, 32'h0000_1770);
        rd(OFS_CLOCK_SETUP, v);
        check("bypass setup", v, 32'h0000_0004);
        check("bypass port", {16'h0, clk_cfg}, 32'h0000_0004);
        pll(F12, F24, 32'h0, 32'h0, 32'h0, F24);
        rd(OFS_CLOCK_SETUP, v);
        check("pll setup", v & 32'h0000_3FFF, 32'h0000_0203);
        check("pll port", {16'h0, clk_cfg} & 32'h0000_3FFF, 32'h0000_0203);
        pll(F12, 32'h0000_61A8, 32'h1, 32'h0, 32'h0, F24);
        pll(F12, 32'h0000_4E20, 32'h2, 32'h0, 32'h0, F24);
        // 19000 kHz: 24000 is nearer than 12000, above the target
        pll(F12, 32'h0000_4A38, 32'h3, 32'h0, 32'h0, F24);
        // 16500 kHz: main clock cap leaves 12000 as the nearest, below the target
        pll(F12, 32'h0000_4074, 32'h3, 32'h0, 32'h0, F12);
        rd(OFS_CLOCK_SETUP, s0);
        pll_lock <= 1'b0;
        pll(F12, F24, 32'h0, 32'h5, 32'h4, F12);
        rd(OFS_CLOCK_SETUP, v);
        check("setup after time-out", v, s0);
        start(F12, F24, 32'h0, 32'h0);
        repeat (2000) @(posedge clk_sys);
        check("busy without lock", {31'h0, busy}, 32'h1);
        pll_lock <= 1'b1;
        wait_idle();
        results(32'h0, F24);
        // poll limit of 24 MHz in Hz over 10000, lock present
        pll(F12, F24, 32'h0, 32'h0000_0960, 32'h0, F24);
        $display("test clock requests done");
        for (int p = 0; p < 4; p++)
        begin
            pwr(32'h18, p, 32'h0);
            rd(OFS_PROFILE, v);
            check("profile", v, p);
            check("profile port", {30'h0, profile}, p);
        end
        pwr(32'h18, 32'h4, 32'h2);
        pwr(32'h0, 32'h1, 32'h1);
        pwr(32'h1F, 32'h1, 32'h1);
        rd(OFS_PROFILE, v);
        check("profile kept", v, 32'h3);
        pwr(32'h1E, 32'h2, 32'h0);
        pwr(32'h1, 32'h1, 32'h0);
        rd(OFS_PROFILE, v);
        check("profile at limits", v, 32'h1);
        $display("test power requests done");
        conclude();
    end
endmodule
